//--- rtl/isa_return_rotate_sub_ops.sv
// Decode and execute of returns, rotates, subtractions, swap, xor,
// power-down and legacy loads, plus the call push the returns rely on.
// Assumes the fetch unit presents one instruction per instruction cycle
// with insn_valid, and the file register read data for insn's address.
`timescale 1ns/10ps
module isa_return_rotate_sub_ops (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Instruction stream
	input wire logic insn_valid,
	input wire logic [13:0] insn,
	input wire logic [isa_ops_pkg::PC_W-1:0] pc,
	input wire logic wake,
	// File register port
	input wire logic [7:0] file_rdata,
	output logic file_we,
	output logic [6:0] file_addr,
	output logic [7:0] file_wdata,
	// Program counter control
	output logic pc_load,
	output logic [isa_ops_pkg::PC_W-1:0] pc_target,
	output logic busy,
	// Architectural state
	output logic [7:0] acc,
	output logic carry_flag,
	output logic half_carry_flag,
	output logic zero_flag,
	output logic global_irq_enable,
	output logic timeout_status_flag,
	output logic power_down_flag,
	output logic [7:0] watchdog_counter,
	output logic [7:0] watchdog_prescaler,
	output logic osc_stop,
	output logic [7:0] option_reg,
	output logic [2:0][7:0] pin_direction
);
	typedef struct packed {
		isa_ops_pkg::core_state_type st;
		logic [7:0] acc;
		logic c;
		logic hc;
		logic z;
		logic irq_en;
		logic to;
		logic pdown;
		logic [7:0] wd_count;
		logic [7:0] wd_pre;
		logic [7:0] option;
		logic [2:0][7:0] dir;
		logic fwe;
		logic [6:0] faddr;
		logic [7:0] fdata;
		logic pcl;
		logic [isa_ops_pkg::PC_W-1:0] pct;
	} core_state_struct_type;

	core_state_struct_type state;
	core_state_struct_type next_state;
	isa_ops_pkg::op_kind_type kind;
	logic [7:0] result;
	logic [8:0] diff;
	logic [4:0] diff_lo;
	logic [7:0] sub_a;
	logic [2:0] pin_direction_load_op_sel;
	stack_if stk ();

	function automatic logic match(input logic [13:0] w, input logic [13:0] m, input logic [13:0] v);
		return (w & m) == v;
	endfunction

	return_stack #(.DEPTH(isa_ops_pkg::STACK_DEPTH)) u_stack (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.stk(stk)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		kind = isa_ops_pkg::OPK_OTHER;
		if (insn == isa_ops_pkg::OP_IRQ_RETURN)
			kind = isa_ops_pkg::OPK_IRQ_RET;
		else if (insn == isa_ops_pkg::OP_RETURN)
			kind = isa_ops_pkg::OPK_RET;
		else if (insn == isa_ops_pkg::OP_POWER_DOWN)
			kind = isa_ops_pkg::OPK_SLEEP;
		else if (insn == isa_ops_pkg::OP_OPTION_LOAD)
			kind = isa_ops_pkg::OPK_OPTION;
		else if (match(insn, isa_ops_pkg::MASK_IDLE, isa_ops_pkg::VAL_IDLE))
			kind = isa_ops_pkg::OPK_IDLE;
		else if (match(insn, isa_ops_pkg::MASK_DIR_LOAD, isa_ops_pkg::VAL_DIR_LOAD))
			kind = isa_ops_pkg::OPK_DIR_LOAD;
		else if (match(insn, isa_ops_pkg::MASK_BYTE, isa_ops_pkg::VAL_ROT_RIGHT))
			kind = isa_ops_pkg::OPK_ROT_RIGHT;
		else if (match(insn, isa_ops_pkg::MASK_BYTE, isa_ops_pkg::VAL_ROT_LEFT))
			kind = isa_ops_pkg::OPK_ROT_LEFT;
		else if (match(insn, isa_ops_pkg::MASK_BYTE, isa_ops_pkg::VAL_REG_SUB))
			kind = isa_ops_pkg::OPK_REG_SUB;
		else if (match(insn, isa_ops_pkg::MASK_BYTE, isa_ops_pkg::VAL_NIBBLE_SWAP))
			kind = isa_ops_pkg::OPK_NIBBLE_SWAP;
		else if (match(insn, isa_ops_pkg::MASK_BYTE, isa_ops_pkg::VAL_REG_XOR))
			kind = isa_ops_pkg::OPK_REG_XOR;
		else if (match(insn, isa_ops_pkg::MASK_BYTE, isa_ops_pkg::VAL_LIT_XOR))
			kind = isa_ops_pkg::OPK_LIT_XOR;
		else if (match(insn, isa_ops_pkg::MASK_LIT2, isa_ops_pkg::VAL_LIT_SUB))
			kind = isa_ops_pkg::OPK_LIT_SUB;
		else if (match(insn, isa_ops_pkg::MASK_LIT4, isa_ops_pkg::VAL_LIT_RETURN))
			kind = isa_ops_pkg::OPK_LIT_RET;
		else if (match(insn, isa_ops_pkg::MASK_CALL, isa_ops_pkg::VAL_CALL))
			kind = isa_ops_pkg::OPK_CALL;
	end

	// Shared subtractor: literal or file operand minus accumulator
	assign sub_a = (kind == isa_ops_pkg::OPK_LIT_SUB) ? insn[7:0] : file_rdata;
	assign diff = {1'b0, sub_a} + {1'b0, ~state.acc} + 9'h001;
	assign diff_lo = {1'b0, sub_a[3:0]} + {1'b0, ~state.acc[3:0]} + 5'h01;
	assign pin_direction_load_op_sel = insn[2:0];

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_state = state;
		next_state.fwe = 1'b0;
		next_state.pcl = 1'b0;
		result = 8'h00;
		stk.push = 1'b0;
		stk.pop = 1'b0;
		stk.push_addr = pc + 13'h0001;
		case (state.st)
			isa_ops_pkg::ST_FLUSH:
				// Second cycle of a branch discards the prefetched word
				next_state.st = isa_ops_pkg::ST_EXEC;
			isa_ops_pkg::ST_HALT:
			begin
				if (wake)
					next_state.st = isa_ops_pkg::ST_EXEC;
			end
			isa_ops_pkg::ST_EXEC:
			begin
				if (insn_valid)
				begin
					case (kind)
						isa_ops_pkg::OPK_IRQ_RET:
						begin
							next_state.pct = stk.stack_top;
							next_state.pcl = 1'b1;
							next_state.irq_en = 1'b1;
							stk.pop = 1'b1;
							next_state.st = isa_ops_pkg::ST_FLUSH;
						end
						isa_ops_pkg::OPK_LIT_RET:
						begin
							next_state.acc = insn[7:0];
							next_state.pct = stk.stack_top;
							next_state.pcl = 1'b1;
							stk.pop = 1'b1;
							next_state.st = isa_ops_pkg::ST_FLUSH;
						end
						isa_ops_pkg::OPK_RET:
						begin
							next_state.pct = stk.stack_top;
							next_state.pcl = 1'b1;
							stk.pop = 1'b1;
							next_state.st = isa_ops_pkg::ST_FLUSH;
						end
						isa_ops_pkg::OPK_CALL:
						begin
							stk.push = 1'b1;
							next_state.pct = {2'b00, insn[10:0]};
							next_state.pcl = 1'b1;
							next_state.st = isa_ops_pkg::ST_FLUSH;
						end
						isa_ops_pkg::OPK_SLEEP:
						begin
							next_state.wd_count = isa_ops_pkg::WATCHDOG_CLEAR;
							next_state.wd_pre = isa_ops_pkg::WATCHDOG_CLEAR;
							next_state.to = 1'b1;
							next_state.pdown = 1'b0;
							next_state.st = isa_ops_pkg::ST_HALT;
						end
						isa_ops_pkg::OPK_ROT_RIGHT, isa_ops_pkg::OPK_ROT_LEFT,
						isa_ops_pkg::OPK_REG_SUB, isa_ops_pkg::OPK_NIBBLE_SWAP, isa_ops_pkg::OPK_REG_XOR:
						begin
							case (kind)
								isa_ops_pkg::OPK_ROT_RIGHT:
								begin
									result = {state.c, file_rdata[7:1]};
									next_state.c = file_rdata[0];
								end
								isa_ops_pkg::OPK_ROT_LEFT:
								begin
									result = {file_rdata[6:0], state.c};
									next_state.c = file_rdata[7];
								end
								isa_ops_pkg::OPK_REG_SUB:
								begin
									result = diff[7:0];
									next_state.c = diff[8];
									next_state.hc = diff_lo[4];
									next_state.z = (diff[7:0] == 8'h00);
								end
								isa_ops_pkg::OPK_NIBBLE_SWAP:
									result = {file_rdata[3:0], file_rdata[7:4]};
								default:
								begin
									result = state.acc ^ file_rdata;
									next_state.z = (result == 8'h00);
								end
							endcase
							if (insn[isa_ops_pkg::DEST_BIT])
							begin
								next_state.fwe = 1'b1;
								next_state.faddr = insn[6:0];
								next_state.fdata = result;
							end
							else
								next_state.acc = result;
						end
						isa_ops_pkg::OPK_LIT_SUB:
						begin
							next_state.acc = diff[7:0];
							next_state.c = diff[8];
							next_state.hc = diff_lo[4];
							next_state.z = (diff[7:0] == 8'h00);
						end
						isa_ops_pkg::OPK_LIT_XOR:
						begin
							next_state.acc = state.acc ^ insn[7:0];
							next_state.z = ((state.acc ^ insn[7:0]) == 8'h00);
						end
						isa_ops_pkg::OPK_DIR_LOAD:
						begin
							if (pin_direction_load_op_sel >= 3'(isa_ops_pkg::DIR_SEL_LO))
								next_state.dir[2'(pin_direction_load_op_sel - 3'(isa_ops_pkg::DIR_SEL_LO))] = state.acc;
						end
						isa_ops_pkg::OPK_OPTION:
							next_state.option = state.acc;
						default:
							;
					endcase
				end
			end
			default:
				next_state.st = isa_ops_pkg::ST_EXEC;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			state <= '0;
			state.st <= isa_ops_pkg::ST_EXEC;
			state.acc <= isa_ops_pkg::ACC_RESET;
			state.to <= 1'b1;
			state.pdown <= 1'b1;
			state.option <= isa_ops_pkg::OPTION_RESET;
			state.dir <= {3{isa_ops_pkg::DIR_RESET}};
			state.pct <= isa_ops_pkg::PC_RESET;
		end
		else
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////
	assign acc = state.acc;
	assign carry_flag = state.c;
	assign half_carry_flag = state.hc;
	assign zero_flag = state.z;
	assign global_irq_enable = state.irq_en;
	assign timeout_status_flag = state.to;
	assign power_down_flag = state.pdown;
	assign watchdog_counter = state.wd_count;
	assign watchdog_prescaler = state.wd_pre;
	assign osc_stop = (state.st == isa_ops_pkg::ST_HALT);
	assign option_reg = state.option;
	assign pin_direction = state.dir;
	assign file_we = state.fwe;
	assign file_addr = state.faddr;
	assign file_wdata = state.fdata;
	assign pc_load = state.pcl;
	assign pc_target = state.pct;
	assign busy = (state.st != isa_ops_pkg::ST_EXEC);

	////////////////////////////////////////////////////////////////////////
	sequence s_return_issue;
		insn_valid && state.st == isa_ops_pkg::ST_EXEC
			&& (kind == isa_ops_pkg::OPK_RET || kind == isa_ops_pkg::OPK_IRQ_RET || kind == isa_ops_pkg::OPK_LIT_RET);
	endsequence

	sequence s_two_cycle;
		pc_load && busy ##1 !busy;
	endsequence

	a_irq_return_gie: assert property (@(posedge core_clk) disable iff (!reset_n)
		insn_valid && state.st == isa_ops_pkg::ST_EXEC && kind == isa_ops_pkg::OPK_IRQ_RET
			|=> global_irq_enable && pc_target == $past(stk.stack_top))
		else $error("interrupt return did not restore pc or set enable");

	a_lit_return_acc: assert property (@(posedge core_clk) disable iff (!reset_n)
		insn_valid && state.st == isa_ops_pkg::ST_EXEC && kind == isa_ops_pkg::OPK_LIT_RET
			|=> acc == $past(insn[7:0]))
		else $error("literal return did not load accumulator");

	a_return_timing: assert property (@(posedge core_clk) disable iff (!reset_n)
		s_return_issue |=> s_two_cycle)
		else $error("return did not take two cycles");

	a_return_flags: assert property (@(posedge core_clk) disable iff (!reset_n)
		insn_valid && state.st == isa_ops_pkg::ST_EXEC && kind == isa_ops_pkg::OPK_RET
			|=> $stable(carry_flag) && $stable(zero_flag) && $stable(half_carry_flag))
		else $error("return altered a flag");

	a_rotate_right: assert property (@(posedge core_clk) disable iff (!reset_n)
		insn_valid && state.st == isa_ops_pkg::ST_EXEC && kind == isa_ops_pkg::OPK_ROT_RIGHT && !insn[7]
			|=> acc == {$past(carry_flag), $past(file_rdata[7:1])} && carry_flag == $past(file_rdata[0]))
		else $error("right rotate wrong");

	a_rotate_left: assert property (@(posedge core_clk) disable iff (!reset_n)
		insn_valid && state.st == isa_ops_pkg::ST_EXEC && kind == isa_ops_pkg::OPK_ROT_LEFT && insn[7]
			|=> file_we && file_wdata == {$past(file_rdata[6:0]), $past(carry_flag)} && carry_flag == $past(file_rdata[7]))
		else $error("left rotate wrong");

	a_sleep_status: assert property (@(posedge core_clk) disable iff (!reset_n)
		insn_valid && state.st == isa_ops_pkg::ST_EXEC && kind == isa_ops_pkg::OPK_SLEEP
			|=> timeout_status_flag && !power_down_flag && watchdog_counter == 8'h00 && osc_stop)
		else $error("power-down status wrong");

	a_sub_carry: assert property (@(posedge core_clk) disable iff (!reset_n)
		insn_valid && state.st == isa_ops_pkg::ST_EXEC && kind == isa_ops_pkg::OPK_LIT_SUB
			|=> carry_flag == ($past(insn[7:0]) >= $past(acc)) && acc == 8'($past(insn[7:0]) - $past(acc)))
		else $error("subtract carry or result wrong");

	a_swap_flags: assert property (@(posedge core_clk) disable iff (!reset_n)
		insn_valid && state.st == isa_ops_pkg::ST_EXEC && kind == isa_ops_pkg::OPK_NIBBLE_SWAP && !insn[7]
			|=> acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && $stable(carry_flag))
		else $error("swap wrong");

	a_call_push: assert property (@(posedge core_clk) disable iff (!reset_n)
		insn_valid && state.st == isa_ops_pkg::ST_EXEC && kind == isa_ops_pkg::OPK_CALL
			|=> ##1 stk.stack_top == $past(pc, 2) + 13'h0001)
		else $error("call did not push next address");
endmodule // isa_return_rotate_sub_ops

//--- rtl/isa_ops_pkg.sv
// Package of opcode patterns, field positions and reset values for the
// return, rotate, subtract and misc instruction decoder.
// Assumes a 14-bit instruction word and an 8-bit data path.
//
// Functional notes
// - Interrupt return pops stack top into program counter, sets global enable, two cycles.
// - Literal return loads immediate into accumulator and pops stack, two cycles.
// - Plain return pops stack into program counter, two cycles, flags untouched.
// - Right rotate through carry: old carry into bit 7, bit 0 to carry.
// - Left rotate through carry: old carry into bit 0, bit 7 to carry.
// - Destination bit 0 writes accumulator, 1 writes the file register.
// - Power-down clears watchdog and prescaler, sets timeout, clears power-down flag, halts.
// - Literal minus accumulator into accumulator, updating carry, half carry, zero.
// - File minus accumulator routed by destination, updating carry, half carry, zero.
// - Subtraction carry is set on non-negative result, cleared on negative.
// - Nibble swap routed by destination, flags unchanged.
// - Xor immediate with accumulator into accumulator, updating zero flag.
// - Pin direction load copies accumulator to register selected 5..7, no flags.
// - Subroutine call pushes address of next instruction onto the stack.
package isa_ops_pkg;
	localparam int INSN_W = 14;
	localparam int DATA_W = 8;
	localparam int PC_W = 13;
	localparam int STACK_DEPTH = 8;
	localparam int FADDR_W = 7;
	localparam int DIR_REG_COUNT = 3;

	// Exact opcodes
	localparam logic [13:0] OP_IRQ_RETURN = 14'h0009;
	localparam logic [13:0] OP_RETURN = 14'h0008;
	localparam logic [13:0] OP_POWER_DOWN = 14'h0063;
	localparam logic [13:0] OP_OPTION_LOAD = 14'h0062;
	// Masked opcodes: match when (insn & mask) == value
	localparam logic [13:0] MASK_IDLE = 14'h3f9f;
	localparam logic [13:0] VAL_IDLE = 14'h0000;
	localparam logic [13:0] MASK_DIR_LOAD = 14'h3ff8;
	localparam logic [13:0] VAL_DIR_LOAD = 14'h0060;
	localparam logic [13:0] MASK_BYTE = 14'h3f00;
	localparam logic [13:0] VAL_ROT_RIGHT = 14'h0c00;
	localparam logic [13:0] VAL_ROT_LEFT = 14'h0d00;
	localparam logic [13:0] VAL_REG_SUB = 14'h0200;
	localparam logic [13:0] VAL_NIBBLE_SWAP = 14'h0e00;
	localparam logic [13:0] VAL_REG_XOR = 14'h0600;
	localparam logic [13:0] VAL_LIT_XOR = 14'h3a00;
	localparam logic [13:0] MASK_LIT2 = 14'h3e00;
	localparam logic [13:0] VAL_LIT_SUB = 14'h3c00;
	localparam logic [13:0] MASK_LIT4 = 14'h3c00;
	localparam logic [13:0] VAL_LIT_RETURN = 14'h3400;
	localparam logic [13:0] MASK_CALL = 14'h3800;
	localparam logic [13:0] VAL_CALL = 14'h2000;

	// Field positions
	localparam int DEST_BIT = 7;
	localparam int DIR_SEL_LO = 5;
	localparam int DIR_SEL_HI = 7;

	// Reset values and the watchdog clear value
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] OPTION_RESET = 8'hff;
	localparam logic [7:0] DIR_RESET = 8'hff;
	localparam logic [7:0] WATCHDOG_CLEAR = 8'h00;
	localparam logic [12:0] PC_RESET = 13'h0000;

	typedef enum {
		ST_EXEC,
		ST_FLUSH,
		ST_HALT
	} core_state_type;

	typedef enum {
		OPK_OTHER,
		OPK_IDLE,
		OPK_IRQ_RET,
		OPK_LIT_RET,
		OPK_RET,
		OPK_ROT_RIGHT,
		OPK_ROT_LEFT,
		OPK_SLEEP,
		OPK_LIT_SUB,
		OPK_REG_SUB,
		OPK_NIBBLE_SWAP,
		OPK_LIT_XOR,
		OPK_REG_XOR,
		OPK_DIR_LOAD,
		OPK_OPTION,
		OPK_CALL
	} op_kind_type;
endpackage

//--- rtl/stack_if.sv
// Interface between the decoder and its hardware return stack.
// Assumes one push or one pop per cycle, never both.
`timescale 1ns/10ps
interface stack_if;
	logic push;
	logic pop;
	logic [isa_ops_pkg::PC_W-1:0] push_addr;
	logic [isa_ops_pkg::PC_W-1:0] stack_top;

	modport core (output push, output pop, output push_addr, input stack_top);
	modport store (input push, input pop, input push_addr, output stack_top);
endinterface

//--- rtl/return_stack.sv
// Circular hardware return stack of flip-flops.
// Assumes overflow silently wraps, as on the original core.
`timescale 1ns/10ps
module return_stack #(
	parameter int DEPTH = isa_ops_pkg::STACK_DEPTH
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Decoder side
	stack_if.store stk
);
	localparam int PTR_W = $clog2(DEPTH);

	typedef struct packed {
		logic [PTR_W-1:0] ptr;
		logic [DEPTH-1:0][isa_ops_pkg::PC_W-1:0] slot;
	} stack_state_type;

	stack_state_type state;
	stack_state_type next_state;

	always_comb
	begin
		next_state = state;
		if (stk.push)
		begin
			next_state.ptr = state.ptr + 1'b1;
			next_state.slot[next_state.ptr] = stk.push_addr;
		end
		else if (stk.pop)
			next_state.ptr = state.ptr - 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			state <= '0;
		else
			state <= next_state;
	end

	assign stk.stack_top = state.slot[state.ptr];
endmodule // return_stack

//--- verif/file_reg_model.sv
// File register model standing on the far side of the decoder.
// Assumes reads are combinational from the instruction's address
// and that writes land on the rising edge of the instruction clock.
`timescale 1ns/10ps
module file_reg_model (
	// Clock
	input wire logic core_clk,
	// Read port
	input wire logic [6:0] rd_addr,
	output logic [7:0] rd_data,
	// Write port
	input wire logic we,
	input wire logic [6:0] wr_addr,
	input wire logic [7:0] wr_data
);
	logic [7:0] mem [128];

	////////////////////////////////////////////////////////////////////////
	// Seed pattern is one the bench can recompute for expected values
	initial
	begin
		for (int i = 0; i < 128; i++)
			mem[i] = 8'(i) ^ 8'ha5;
	end

	assign rd_data = mem[rd_addr];

	always @(posedge core_clk)
	begin
		if (we)
			mem[wr_addr] <= wr_data;
	end
endmodule // file_reg_model

//--- verif/isa_return_rotate_sub_ops_tb.sv
// Self-checking bench for the return, rotate, subtract and misc decoder.
// Assumes the design package, the stack and the file register model are compiled first.
`timescale 1ns/10ps
module isa_return_rotate_sub_ops_tb;
	logic core_clk, reset_n, insn_valid, wake, file_we, pc_load, busy;
	logic [13:0] insn;
	logic [isa_ops_pkg::PC_W-1:0] pc, pc_target;
	logic [7:0] file_rdata, file_wdata, acc, watchdog_counter, watchdog_prescaler, option_reg;
	logic [6:0] file_addr;
	logic carry_flag, half_carry_flag, zero_flag, global_irq_enable;
	logic timeout_status_flag, power_down_flag, osc_stop;
	logic [2:0][7:0] pin_direction;
	int failures = 0;
	int checks = 0;
	logic [7:0] a = 8'h00;
	logic c = 1'h0;
	logic hc = 1'h0;
	logic z = 1'h0;
	logic [7:0] ks [4] = '{8'h02, 8'h02, 8'h02, 8'h20};
	logic [7:0] ws [4] = '{8'h01, 8'h02, 8'h03, 8'h01};

	isa_return_rotate_sub_ops dut (.core_clk, .reset_n, .insn_valid, .insn, .pc, .wake, .file_rdata,
		.file_we, .file_addr, .file_wdata, .pc_load, .pc_target, .busy, .acc, .carry_flag,
		.half_carry_flag, .zero_flag, .global_irq_enable, .timeout_status_flag, .power_down_flag,
		.watchdog_counter, .watchdog_prescaler, .osc_stop, .option_reg, .pin_direction);

	file_reg_model files (.core_clk, .rd_addr(insn[6:0]), .rd_data(file_rdata), .we(file_we),
		.wr_addr(file_addr), .wr_data(file_wdata));

	initial
	begin
		core_clk = 1'h0;
		forever #20 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic chk_core(input string what);
		chk(what, {5'h00, c, hc, z, a}, {5'h00, carry_flag, half_carry_flag, zero_flag, acc});
	endtask

	// Leaves valid up so a second call issues back to back
	task automatic issue(input logic [13:0] op, input logic [12:0] p = 13'h0000);
		insn <= op;
		pc <= p;
		insn_valid <= 1'h1;
		@(posedge core_clk);
	endtask

	// Samples at the falling edge, once registered results have landed
	task automatic finish_op;
		insn_valid <= 1'h0;
		@(negedge core_clk);
	endtask

	task automatic run(input logic [13:0] op, input logic [12:0] p = 13'h0000);
		@(posedge core_clk);
		issue(op, p);
		finish_op();
	endtask

	task automatic setacc(input logic [7:0] v);
		run({6'h3a, a ^ v});
		a = v;
		z = (v == 8'h00);
	endtask

	task automatic sub_exp(input logic [7:0] k, input logic [7:0] w, output logic [7:0] r);
		r = k - w;
		c = (k >= w);
		hc = (k[3:0] >= w[3:0]);
		z = (r == 8'h00);
	endtask

	// One byte-oriented file op with its expected result worked out first
	task automatic byte_op(input logic [5:0] opc, input logic d, input logic [6:0] fa);
		logic [7:0] f;
		logic [7:0] r;
		f = {1'h0, fa} ^ 8'ha5;
		if (opc == 6'h0c)
			{r, c} = {c, f};
		else if (opc == 6'h0d)
			{c, r} = {f, c};
		else if (opc == 6'h0e)
			r = {f[3:0], f[7:4]};
		else if (opc == 6'h02)
			sub_exp(f, a, r);
		else
		begin
			r = f ^ a;
			z = (r == 8'h00);
		end
		run({opc, d, fa});
		if (d)
			chk("file write", {1'h1, fa, r}, {file_we, file_addr, file_wdata});
		else
		begin
			chk("no file write", 16'h0000, {15'h0000, file_we});
			a = r;
		end
		chk_core("byte op");
	endtask

	task automatic branch(input logic [13:0] op, input logic [12:0] p, input logic [12:0] tgt);
		run(op, p);
		chk("branch", {3'h3, tgt}, {1'h0, pc_load, busy, pc_target});
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		reset_n = 1'h0;
		insn_valid = 1'h0;
		insn = 14'h0000;
		pc = 13'h0000;
		wake = 1'h0;
		repeat (4) @(posedge core_clk);
		reset_n <= 1'h1;
		@(negedge core_clk);
		chk("reset state", 16'h000c, {acc, carry_flag, half_carry_flag, zero_flag, global_irq_enable,
			timeout_status_flag, power_down_flag, busy, file_we});
		chk("option reset", 16'h00ff, {8'h00, option_reg});
		$display("done: reset");

		setacc(8'h00);
		chk_core("xor zero");
		setacc(8'hb5);
		chk_core("xor value");
		// Load and subtract issued back to back
		for (int i = 0; i < 4; i++)
		begin
			@(posedge core_clk);
			issue({6'h3a, a ^ ws[i]});
			issue({5'h1e, i[0], ks[i]});
			finish_op();
			sub_exp(ks[i], ws[i], a);
			chk_core("literal subtract");
		end
		$display("done: literal ops");

		setacc(8'h05);
		byte_op(6'h02, 1'h1, 7'h10);
		byte_op(6'h02, 1'h0, 7'h11);
		byte_op(6'h0c, 1'h0, 7'h21);
		byte_op(6'h0c, 1'h1, 7'h22);
		byte_op(6'h0d, 1'h1, 7'h33);
		byte_op(6'h0d, 1'h0, 7'h34);
		byte_op(6'h0e, 1'h0, 7'h00);
		byte_op(6'h0e, 1'h1, 7'h41);
		byte_op(6'h06, 1'h1, 7'h05);
		byte_op(6'h06, 1'h0, 7'h5a);
		$display("done: file ops");

		setacc(8'h3c);
		run(14'h0062);
		chk("option load", {8'h00, a}, {8'h00, option_reg});
		run(14'h0061);
		chk("selector outside range", 16'h00ff, {8'h00, pin_direction[0]});
		for (int s = 5; s < 8; s++)
		begin
			setacc(8'h10 + 8'(s));
			run({11'h00c, 3'(s)});
			chk("pin direction", {8'h00, a}, {8'h00, pin_direction[s-5]});
		end
		chk_core("legacy flags");
		foreach (ks[i])
		begin
			if (i < 3)
			begin
				run({7'h00, 2'(i), 5'h00});
				chk("idle", 16'h0000, {14'h0000, file_we, pc_load});
			end
		end
		chk_core("idle state");
		$display("done: legacy and idle");

		branch(14'h2123, 13'h0100, 13'h0123);
		branch(14'h2456, 13'h0200, 13'h0456);
		branch(14'h0008, 13'h0000, 13'h0201);
		chk_core("return flags");
		branch(14'h3677, 13'h0000, 13'h0101);
		a = 8'h77;
		chk_core("literal return");
		branch(14'h27ff, 13'h0300, 13'h07ff);
		chk("irq enable before", 16'h0000, {15'h0000, global_irq_enable});
		branch(14'h0009, 13'h0000, 13'h0301);
		chk("irq enable after", 16'h0001, {15'h0000, global_irq_enable});
		$display("done: calls and returns");

		run(14'h0063);
		chk("power down", 16'he000, {busy, osc_stop, timeout_status_flag, power_down_flag, 12'h000});
		chk("watchdog", 16'h0000, {watchdog_counter, watchdog_prescaler});
		run({6'h3a, 8'hff});
		chk_core("halted refuses");
		@(posedge core_clk);
		wake <= 1'h1;
		@(posedge core_clk);
		wake <= 1'h0;
		@(negedge core_clk);
		chk("woken", 16'h0000, {14'h0000, osc_stop, busy});
		setacc(8'h01);
		chk_core("after wake");
		$display("done: power down");
		test_done();
	end

	// Whole sequence needs well under a thousand cycles
	initial
	begin
		#100000;
		failures++;
		test_done();
	end
endmodule // isa_return_rotate_sub_ops_tb
